/* File: hw/bgd_gate_logic.sv */
/*
 gate-drive steering for a synchronous buck stage: mode select,
 interlock, tri-state shutdown, supply lockout, regulator disable.
 assumes all inputs are asynchronous pins; all but regulator disable are synchronised here.
*/
`timescale 1ns/10ps
// Function
// - mode high: pwm times both gates
// - synchronous mode held past its first cycle: gates never both on
// - sync, enable low: low gate off
// - sync, enable high: low gate follows inverted pwm
// - mode low: enable drives low gate
// - mode low: pwm drives high gate
// - independent mode: no interlock or dead time
// - regulator disable high turns regulator off
// - sync: pwm high hs on, low ls on if enable high
// - pwm mid-level held past hold-off: both gates low
// - no gate pulses under supply lockout
module bgd_gate_logic
   import bgd_pkg::*;
#(
   parameter int unsigned HOLDOFF_CYC = TRI_HOLDOFF_CYC,
   parameter int unsigned DEAD_T_CYC = DEAD_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // pins from the controller
   input wire logic pwm_high_pin,
   input wire logic pwm_mid_pin,
   input wire logic lowside_enable_input,
   input wire logic gate_mode_select,
   input wire logic gate_regulator_disable,
   // power stage sense
   input wire logic switch_node_sense,
   input wire logic gate_drive_supply_ok,
   // outputs
   output logic hs_gate,
   output logic ls_gate,
   output logic regulator_off,
   output logic tri_state_active
);
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic [7:0] mid_cnt_r;
   logic [7:0] mid_cnt_nxt;
   logic [7:0] dead_cnt_r;
   logic [7:0] dead_cnt_nxt;
   logic hs_r;
   logic ls_r;
   logic tri_r;
   logic regoff_r;
   logic prev_hs_r;
   bgd_in_t in_s;
   bgd_gate_t want;
   wire tri_det;
   wire sync_mode;
   wire want_hs;
   wire want_ls;
   wire dead_done;
   wire hs_ok;
   wire ls_ok;
   wire side_change;

   assign in_s = bgd_in_t'(sync2_r);
   assign sync_mode = in_s.gate_mode_select;
   assign tri_det = (mid_cnt_r >= 8'(HOLDOFF_CYC));
   // requested gate states per mode
   assign want_hs = in_s.pwm_high;
   assign want_ls = sync_mode ? (~in_s.pwm_high & in_s.lowside_enable_input)
                              : in_s.lowside_enable_input;
   assign want.hs_gate = want_hs & in_s.supply_good & ~tri_det;
   assign want.ls_gate = want_ls & in_s.supply_good & ~tri_det;
   // interlock only in synchronous mode
   assign side_change = want.hs_gate != prev_hs_r;
   assign dead_done = (dead_cnt_r >= 8'(DEAD_T_CYC));
   // high side waits for low gate off and dead time; low waits for high gate off, dead time and switch node low
   assign hs_ok = ~sync_mode | (~ls_r & dead_done);
   assign ls_ok = ~sync_mode | (~hs_r & dead_done & ~in_s.switch_node_sense);
   assign mid_cnt_nxt = in_s.pwm_mid ? ((mid_cnt_r == 8'hff) ? mid_cnt_r : mid_cnt_r + 8'h01)
                                     : CNT_RST;
   assign dead_cnt_nxt = side_change ? CNT_RST
                         : (dead_done ? dead_cnt_r : dead_cnt_r + 8'h01);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end else begin
         sync1_r <= {pwm_high_pin, pwm_mid_pin, lowside_enable_input, gate_mode_select,
                     switch_node_sense, gate_drive_supply_ok};
         sync2_r <= sync1_r;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mid_cnt_r <= CNT_RST;
         dead_cnt_r <= CNT_RST;
         prev_hs_r <= GATE_RST;
         hs_r <= GATE_RST;
         ls_r <= GATE_RST;
         tri_r <= 1'b0;
         regoff_r <= 1'b0;
      end else begin
         mid_cnt_r <= mid_cnt_nxt;
         dead_cnt_r <= dead_cnt_nxt;
         prev_hs_r <= want.hs_gate;
         hs_r <= want.hs_gate & hs_ok;
         ls_r <= want.ls_gate & ls_ok;
         tri_r <= tri_det;
         regoff_r <= gate_regulator_disable;
      end
   end

   assign hs_gate = hs_r;
   assign ls_gate = ls_r;
   assign tri_state_active = tri_r;
   assign regulator_off = regoff_r;

   a_no_overlap: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && $stable(sync_mode) |-> !(hs_r && ls_r))
      else $error("both gates on in synchronous mode");
   a_ls_disabled: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && !in_s.lowside_enable_input |=> !ls_r)
      else $error("low gate on while disabled");
   a_tri_off: assert property (@(posedge clock) disable iff (!rst_b)
      tri_det |=> !hs_r && !ls_r)
      else $error("gate on during tri-state");
   a_uvlo_off: assert property (@(posedge clock) disable iff (!rst_b)
      !in_s.supply_good |=> !hs_r && !ls_r)
      else $error("gate on under lockout");
   a_indep_hs: assert property (@(posedge clock) disable iff (!rst_b)
      !sync_mode && in_s.supply_good && !tri_det |=> hs_r == $past(in_s.pwm_high))
      else $error("high gate not following pwm");
   a_indep_ls: assert property (@(posedge clock) disable iff (!rst_b)
      !sync_mode && in_s.supply_good && !tri_det |=> ls_r == $past(in_s.lowside_enable_input))
      else $error("low gate not following enable");
   a_sync_hs_low: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && !in_s.pwm_high |=> !hs_r)
      else $error("high gate on with pwm low");
   a_sync_ls_pwm: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && in_s.pwm_high |=> !ls_r)
      else $error("low gate on with pwm high");
   a_reg_disable: assert property (@(posedge clock) disable iff (!rst_b)
      gate_regulator_disable |=> regulator_off)
      else $error("regulator not disabled");
   a_reset_low: assert property (@(posedge clock)
      !rst_b |=> !hs_r && !ls_r)
      else $error("gate on after reset");

   // multi-step behaviours
   sequence s_mid_start;
      !in_s.pwm_mid ##1 in_s.pwm_mid;
   endsequence

   sequence s_sync_steady;
      sync_mode && $past(sync_mode);
   endsequence

   sequence s_supply_low;
      !in_s.supply_good ##1 !in_s.supply_good;
   endsequence

   a_tri_holdoff: assert property (@(posedge clock) disable iff (!rst_b)
      s_mid_start |-> !tri_det)
      else $error("tri-state taken before hold-off");
   a_tri_reset: assert property (@(posedge clock) disable iff (!rst_b)
      !in_s.pwm_mid |=> !tri_det)
      else $error("tri-state kept without mid level");
   a_tri_flag: assert property (@(posedge clock) disable iff (!rst_b)
      tri_det |=> tri_state_active)
      else $error("tri-state flag not raised");
   a_tri_flag_src: assert property (@(posedge clock) disable iff (!rst_b)
      tri_state_active |-> $past(tri_det))
      else $error("tri-state flag without detection");
   a_gates_no_tri: assert property (@(posedge clock) disable iff (!rst_b)
      hs_r || ls_r |-> $past(!tri_det))
      else $error("gate raised during tri-state");

   a_hs_after_ls: assert property (@(posedge clock) disable iff (!rst_b)
      s_sync_steady ##0 $rose(hs_r) |-> $past(!ls_r))
      else $error("high gate raised while low gate on");
   a_ls_after_hs: assert property (@(posedge clock) disable iff (!rst_b)
      s_sync_steady ##0 $rose(ls_r) |-> $past(!hs_r) && $past(!in_s.switch_node_sense))
      else $error("low gate raised before switch node low");
   a_sense_blocks: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && in_s.switch_node_sense |=> !ls_r)
      else $error("low gate on with switch node high");
   a_sync_ls_follow: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && in_s.lowside_enable_input && !in_s.pwm_high && in_s.supply_good
      && !tri_det && !in_s.switch_node_sense && !hs_r && dead_done |=> ls_r)
      else $error("low gate not following pwm low");
   a_sync_hs_follow: assert property (@(posedge clock) disable iff (!rst_b)
      sync_mode && in_s.pwm_high && in_s.supply_good && !tri_det && !ls_r && dead_done
      |=> hs_r)
      else $error("high gate not following pwm high");
   a_hs_needs_pwm: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(hs_r) |-> $past(in_s.pwm_high))
      else $error("high gate raised without pwm");
   a_ls_needs_en: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(ls_r) |-> $past(in_s.lowside_enable_input))
      else $error("low gate raised without enable");

   a_supply_hold: assert property (@(posedge clock) disable iff (!rst_b)
      s_supply_low |-> !hs_r && !ls_r)
      else $error("gate on during lockout");
   a_gates_supply: assert property (@(posedge clock) disable iff (!rst_b)
      hs_r || ls_r |-> $past(in_s.supply_good))
      else $error("gate raised without supply");

   a_reg_enable: assert property (@(posedge clock) disable iff (!rst_b)
      !gate_regulator_disable |=> !regulator_off)
      else $error("regulator not running");
   a_reg_follow: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) |-> regulator_off == $past(gate_regulator_disable))
      else $error("regulator state not following pin");
   a_reset_flags: assert property (@(posedge clock)
      !rst_b |=> !regulator_off && !tri_state_active)
      else $error("status set after reset");
endmodule

/* File: hw/bgd_pkg.sv */
/*
 gate-drive mode logic package: constants and carrier structs.
 assumes one 200 MHz clock and synchronous active-low reset.
*/
package bgd_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // tri-state hold-off before both gates are forced off
   localparam int unsigned TRI_HOLDOFF_NS = 100;
   localparam int unsigned TRI_HOLDOFF_CYC =
      (TRI_HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // least dead time between one gate off and the other on
   localparam int unsigned DEAD_NS = 20;
   localparam int unsigned DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic GATE_RST = 1'b0;

   // pin inputs after the synchronisers
   typedef struct packed {
      logic pwm_high;
      logic pwm_mid;
      logic lowside_enable_input;
      logic gate_mode_select;
      logic switch_node_sense;
      logic supply_good;
   } bgd_in_t;

   // gate drive outputs
   typedef struct packed {
      logic hs_gate;
      logic ls_gate;
   } bgd_gate_t;
endpackage

/* File: test/bgd_ctrl_model.sv */
/*
 controller model: drives the gate-drive pins from bench requests.
 assumes requests change just after a rising edge.
*/
`timescale 1ns/10ps
module bgd_ctrl_model
   import bgd_pkg::*;
(
   // clock
   input wire logic clock,
   // request and pins
   input wire bgd_in_t req,
   output bgd_in_t pins
);
   bgd_in_t fix;
   always_comb begin
      fix = req;
      fix.gate_mode_select = (req.gate_mode_select === 1'b1);
      fix.lowside_enable_input = req.lowside_enable_input
         & ~(~fix.gate_mode_select & req.pwm_high);
   end
   always_ff @(posedge clock) begin
      pins <= fix;
   end
endmodule

/* File: test/buck_gate_drive_mode_logic_test.sv */
/*
 bench for the gate-drive steering logic.
 assumes the controller model in front of the pins.
*/
`timescale 1ns/10ps
module buck_gate_drive_mode_logic_test
   import bgd_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic dis = 1'b0;
   logic roff, tri_act;
   bgd_in_t req = '0;
   bgd_in_t pins;
   bgd_gate_t g;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   initial begin
      forever #2.5 clock = ~clock;
   end
   bgd_ctrl_model ctl (.clock(clock), .req(req), .pins(pins));
   bgd_gate_logic #(.HOLDOFF_CYC(2), .DEAD_T_CYC(1)) dut (
      .clock(clock), .rst_b(rst_b), .pwm_high_pin(pins.pwm_high),
      .pwm_mid_pin(pins.pwm_mid), .lowside_enable_input(pins.lowside_enable_input),
      .gate_mode_select(pins.gate_mode_select), .gate_regulator_disable(dis),
      .switch_node_sense(pins.switch_node_sense), .gate_drive_supply_ok(pins.supply_good),
      .hs_gate(g.hs_gate), .ls_gate(g.ls_gate), .regulator_off(roff),
      .tri_state_active(tri_act));
   task automatic conclude;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // bits: pwm mid en mode sense ok dis; expect: hs ls roff tri
   task automatic step(input logic [6:0] s, input logic [3:0] e);
      logic [3:0] got;
      @(posedge clock);
      req <= s[6:1];
      dis <= s[0];
      repeat (12) @(posedge clock);
      #1;
      got = {g.hs_gate, g.ls_gate, roff, tri_act};
      cmp_count++;
      if (got !== e) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 400) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      step(7'b1000010, 4'b0000);
      @(posedge clock);
      rst_b <= 1'b1;
      step(7'b1000010, 4'b1000);
      step(7'b0010010, 4'b0100);
      step(7'b0010110, 4'b0100);
      step(7'b1011010, 4'b1000);
      step(7'b0011110, 4'b0000);
      step(7'b0011010, 4'b0100);
      step(7'b0001010, 4'b0000);
      step(7'b0111010, 4'b0001);
      step(7'b1011000, 4'b0000);
      step(7'b1011011, 4'b1010);
      step(7'b1011010, 4'b1000);
      conclude();
   end
endmodule
